// ===== design/calreg_pkg.sv
// package of offsets, field layouts and reset values for the calibration register slice
package calreg_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_OFS_HIGH = 8'h0f;
   localparam logic [7:0] IDX_OFS_LOW = 8'h10;
   localparam logic [7:0] IDX_GAIN_HIGH = 8'h11;
   localparam logic [7:0] IDX_GAIN_LOW = 8'h12;
   localparam logic [7:0] IDX_CFG2 = 8'h13;
   // byte address of a register index
   localparam int ADDR_SHIFT = 2;
   localparam int ADDR_W = 8;
   // reset values
   localparam logic [15:0] RST_OFS_HIGH = 16'h0000;
   localparam logic [15:0] RST_OFS_LOW = 16'h0000;
   localparam logic [15:0] RST_GAIN_HIGH = 16'h8000;
   localparam logic [15:0] RST_GAIN_LOW = 16'h0000;
   localparam logic [15:0] RST_CFG2 = 16'h0000;
   // writable masks; reserved bits are zero here
   localparam logic [15:0] MASK_FULL = 16'hffff;
   localparam logic [15:0] MASK_LOW = 16'hff00;
   localparam logic [15:0] MASK_CFG2 = 16'hffc7;
   // field positions in the channel two configuration word and the upper byte of the low registers
   localparam int PHASE_HI = 15;
   localparam int PHASE_LO = 6;
   localparam int HPOFF_BIT = 2;
   localparam int SEL_HI = 1;
   localparam int SEL_LO = 0;
   localparam int LOWBYTE_HI = 15;
   localparam int LOWBYTE_LO = 8;
   // input source encodings
   typedef enum logic [1:0] {
      SRC_PINS = 2'h0,
      SRC_SHORT = 2'h1,
      SRC_POS_TEST = 2'h2,
      SRC_NEG_TEST = 2'h3
   } input_src_t;
   // values handed to the conversion datapath
   typedef struct packed {
      logic signed [23:0] offset;
      logic [23:0] gain;
      logic signed [9:0] sample_delay;
      logic highpass_off;
      input_src_t input_select;
   } cal_out_t;
endpackage : calreg_pkg

// ===== design/calreg_word.sv
// one 16-bit register with write mask, byte enables and reset value
`timescale 1ns/1ps
module calreg_word
   import calreg_pkg::*;
#(
   parameter logic [15:0] RESET_VAL = 16'h0000,
   parameter logic [15:0] WMASK = 16'hffff
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // write port
   input wire logic wr_i,
   input wire logic [1:0] be_i,
   input wire logic [15:0] wdata_i,
   // stored value
   output logic [15:0] value_o
);
   logic [15:0] value_ff;
   logic [15:0] lane_mask;
   logic [15:0] nxt_value;

   // only lanes selected by the bus and writable bits change
   assign lane_mask = {{8{be_i[1]}}, {8{be_i[0]}}} & WMASK;
   assign nxt_value = (value_ff & ~lane_mask) | (wdata_i & lane_mask);

   // reserved bits stay at their reset zero because the mask never opens them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         value_ff <= RESET_VAL;
      end else if (wr_i) begin
         value_ff <= nxt_value;
      end
   end

   assign value_o = value_ff;
endmodule : calreg_word

// ===== design/calreg_bank.sv
// wishbone register slice holding channel one calibration and channel two configuration
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
// Contract
// R01: offset high register holds offset bits 23:8
// R02: offset low bits 15:8 hold offset 7:0
// R03: assembled offset is signed two's complement
// R04: low registers bits 7:0 read zero
// R05: gain high register holds gain bits 23:8
// R06: gain low bits 15:8 hold gain 7:0
// R07: gain is unsigned factor below two
// R08: gain high resets 8000, low resets zero
// R09: config bits 15:6 signed sample delay
// R10: config bit 2 turns highpass off
// R11: config bits 1:0 select input source
// R12: config word resets to zero
// R13: offset low register resets to zero
// R14: offset high at index 0f, resets zero
// R15: reserved bits ignore writes, read zero
// R16: assembled values drive datapath continuously
module calreg_bank
   import calreg_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // datapath values
   output cal_out_t cal_o
);
   // register index from a byte address
   function automatic logic [ADDR_W-1:0] to_index(input logic [ADDR_W-1:0] a);
      to_index = a >> ADDR_SHIFT;
   endfunction : to_index

   logic ack_ff; // one-cycle acknowledge
   logic [31:0] rdata_ff; // read data captured with the acknowledge
   logic req; // new request this cycle
   logic wr_en; // write strobe for the addressed register
   logic [ADDR_W-1:0] idx; // decoded register index
   logic hit_oh; // offset high selected
   logic hit_ol; // offset low selected
   logic hit_gh; // gain high selected
   logic hit_gl; // gain low selected
   logic hit_cfg; // channel two config selected
   logic any_hit; // some mapped register selected
   logic [15:0] ofs_high; // offset bits 23:8
   logic [15:0] ofs_low; // offset bits 7:0 in the upper byte
   logic [15:0] gain_high; // gain bits 23:8
   logic [15:0] gain_low; // gain bits 7:0 in the upper byte
   logic [15:0] cfg2; // channel two configuration word
   logic [15:0] rsel; // read mux result
   logic [1:0] be; // byte enables for the low half word

   // request is taken once; ack drops the cycle after it rose
   assign req = cyc_i & stb_i & ~ack_ff;
   assign wr_en = req & we_i;
   assign idx = to_index(adr_i);
   assign be = sel_i[1:0];
   assign hit_oh = (idx == IDX_OFS_HIGH); // [R14]
   assign hit_ol = (idx == IDX_OFS_LOW);
   assign hit_gh = (idx == IDX_GAIN_HIGH);
   assign hit_gl = (idx == IDX_GAIN_LOW);
   assign hit_cfg = (idx == IDX_CFG2);
   // unmapped indices still answer, so the checks need to know when nothing matched
   assign any_hit = hit_oh | hit_ol | hit_gh | hit_gl | hit_cfg;

   // offset high: full 16-bit field, reset zero
   calreg_word #(.RESET_VAL(RST_OFS_HIGH), .WMASK(MASK_FULL)) u_ofs_high ( // [R01] [R14]
      .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_en & hit_oh), .be_i(be),
      .wdata_i(dat_i[15:0]), .value_o(ofs_high));
   // offset low: upper byte only, reserved low byte masked
   calreg_word #(.RESET_VAL(RST_OFS_LOW), .WMASK(MASK_LOW)) u_ofs_low ( // [R02] [R04] [R13] [R15]
      .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_en & hit_ol), .be_i(be),
      .wdata_i(dat_i[15:0]), .value_o(ofs_low));
   // gain high: resets to unity gain
   calreg_word #(.RESET_VAL(RST_GAIN_HIGH), .WMASK(MASK_FULL)) u_gain_high ( // [R05] [R08]
      .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_en & hit_gh), .be_i(be),
      .wdata_i(dat_i[15:0]), .value_o(gain_high));
   // gain low: upper byte only
   calreg_word #(.RESET_VAL(RST_GAIN_LOW), .WMASK(MASK_LOW)) u_gain_low ( // [R06] [R04] [R08] [R15]
      .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_en & hit_gl), .be_i(be),
      .wdata_i(dat_i[15:0]), .value_o(gain_low));
   // channel two config: bits 5:3 reserved
   calreg_word #(.RESET_VAL(RST_CFG2), .WMASK(MASK_CFG2)) u_cfg2 ( // [R09] [R12] [R15]
      .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_en & hit_cfg), .be_i(be),
      .wdata_i(dat_i[15:0]), .value_o(cfg2));

   // read mux; unmapped indices read zero but still acknowledge
   assign rsel = hit_oh ? ofs_high :
                 hit_ol ? ofs_low :
                 hit_gh ? gain_high :
                 hit_gl ? gain_low :
                 hit_cfg ? cfg2 : 16'h0000;

   // acknowledge and read data are registered; answer one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= req;
         if (req) begin
            rdata_ff <= {16'h0000, rsel};
         end
      end
   end

   assign ack_o = ack_ff;
   assign dat_o = rdata_ff;

   // assembled outputs follow the registers with no extra delay
   assign cal_o.offset = $signed({ofs_high, ofs_low[LOWBYTE_HI:LOWBYTE_LO]}); // [R03] [R16]
   assign cal_o.gain = {gain_high, gain_low[LOWBYTE_HI:LOWBYTE_LO]}; // [R07] [R16]
   assign cal_o.sample_delay = $signed(cfg2[PHASE_HI:PHASE_LO]); // [R09]
   assign cal_o.highpass_off = cfg2[HPOFF_BIT]; // [R10]
   assign cal_o.input_select = input_src_t'(cfg2[SEL_HI:SEL_LO]); // [R11]

   // checks
   property p_ofs_high_split;
      @(posedge clk_i) disable iff (rst_i) cal_o.offset[23:8] == ofs_high;
   endproperty
   a_ofs_high_split: assert property (p_ofs_high_split) else $error("offset high bits misplaced"); // [R01]
   property p_ofs_low_split;
      @(posedge clk_i) disable iff (rst_i) cal_o.offset[7:0] == ofs_low[15:8];
   endproperty
   a_ofs_low_split: assert property (p_ofs_low_split) else $error("offset low bits misplaced"); // [R02]
   property p_offset_sign;
      @(posedge clk_i) disable iff (rst_i) (cal_o.offset < 0) == ofs_high[15];
   endproperty
   a_offset_sign: assert property (p_offset_sign) else $error("offset sign wrong"); // [R03]
   property p_low_reserved;
      @(posedge clk_i) disable iff (rst_i) ack_ff && $past(hit_ol || hit_gl) |-> (dat_o[15:0] & ~MASK_LOW) == 16'h0000;
   endproperty
   a_low_reserved: assert property (p_low_reserved) else $error("reserved low byte nonzero"); // [R04]
   property p_gain_split;
      @(posedge clk_i) disable iff (rst_i) cal_o.gain == {gain_high, gain_low[15:8]};
   endproperty
   a_gain_split: assert property (p_gain_split) else $error("gain assembly wrong"); // [R05]
   property p_gain_reset;
      @(posedge clk_i) $fell(rst_i) |-> gain_high == RST_GAIN_HIGH && gain_low == RST_GAIN_LOW;
   endproperty
   a_gain_reset: assert property (p_gain_reset) else $error("gain reset wrong"); // [R08]
   property p_cfg_reset;
      @(posedge clk_i) $fell(rst_i) |-> cfg2 == RST_CFG2 && ofs_low == RST_OFS_LOW && ofs_high == RST_OFS_HIGH;
   endproperty
   a_cfg_reset: assert property (p_cfg_reset) else $error("config or offset reset wrong"); // [R12]
   property p_cfg_reserved;
      @(posedge clk_i) disable iff (rst_i) (cfg2 & ~MASK_CFG2) == 16'h0000;
   endproperty
   a_cfg_reserved: assert property (p_cfg_reserved) else $error("config reserved bits set"); // [R15]
   property p_cfg_write;
      @(posedge clk_i) disable iff (rst_i) wr_en && hit_cfg && sel_i[1:0] == 2'h3 |=>
         cal_o.highpass_off == $past(dat_i[2]) && cal_o.input_select == $past(dat_i[1:0]);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost"); // [R10]
   property p_ack_once;
      @(posedge clk_i) disable iff (rst_i) cyc_i && stb_i && !ack_ff |=> ack_ff ##1 !ack_ff;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
   c_cfg_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_en && hit_cfg);
   c_neg_offset: cover property (@(posedge clk_i) disable iff (rst_i) cal_o.offset < 0);
   c_read_gain: cover property (@(posedge clk_i) disable iff (rst_i) req && !we_i && hit_gh);
   c_unmapped_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_en && !any_hit);
   c_neg_test_src: cover property (@(posedge clk_i) disable iff (rst_i) cal_o.input_select == SRC_NEG_TEST);

   // field mapping: a write taken on one edge shows in the datapath value by the next

   // full offset high write lands in the top sixteen bits
   property p_ofs_high_write;
      @(posedge clk_i) disable iff (rst_i) wr_en && hit_oh && be == 2'h3 |=> cal_o.offset[23:8] == $past(dat_i[15:0]);
   endproperty
   a_ofs_high_write: assert property (p_ofs_high_write) else $error("offset high write lost"); // [R01]

   // no lane selected means no change, a partial bus must not clobber the word
   property p_ofs_be_gate;
      @(posedge clk_i) disable iff (rst_i) wr_en && hit_oh && be == 2'h0 |=> $stable(ofs_high);
   endproperty
   a_ofs_be_gate: assert property (p_ofs_be_gate) else $error("offset high changed without lanes"); // [R01]

   // upper byte of offset low becomes the bottom offset byte
   property p_ofs_low_write;
      @(posedge clk_i) disable iff (rst_i) wr_en && hit_ol && be[1] |=> cal_o.offset[7:0] == $past(dat_i[15:8]);
   endproperty
   a_ofs_low_write: assert property (p_ofs_low_write) else $error("offset low write lost"); // [R02]

   // the stored low bytes never hold anything, whatever was written
   property p_low_rsv_store;
      @(posedge clk_i) disable iff (rst_i) (ofs_low & ~MASK_LOW) == 16'h0000 && (gain_low & ~MASK_LOW) == 16'h0000;
   endproperty
   a_low_rsv_store: assert property (p_low_rsv_store) else $error("reserved low byte stored"); // [R04]

   // full gain high write lands in the top sixteen bits
   property p_gain_high_write;
      @(posedge clk_i) disable iff (rst_i) wr_en && hit_gh && be == 2'h3 |=> cal_o.gain[23:8] == $past(dat_i[15:0]);
   endproperty
   a_gain_high_write: assert property (p_gain_high_write) else $error("gain high write lost"); // [R05]

   // a read of gain high returns the word held when the request was taken
   property p_gain_high_read;
      @(posedge clk_i) disable iff (rst_i) ack_ff && !$past(we_i) && $past(hit_gh) |-> dat_o[15:0] == $past(gain_high);
   endproperty
   a_gain_high_read: assert property (p_gain_high_read) else $error("gain high read wrong"); // [R05]

   // upper byte of gain low becomes the bottom gain byte
   property p_gain_low_write;
      @(posedge clk_i) disable iff (rst_i) wr_en && hit_gl && be[1] |=> cal_o.gain[7:0] == $past(dat_i[15:8]);
   endproperty
   a_gain_low_write: assert property (p_gain_low_write) else $error("gain low write lost"); // [R06]

   // gain is a magnitude: a set top bit is a large factor, never a negative one
   property p_gain_unsigned;
      @(posedge clk_i) disable iff (rst_i) gain_high[15] |-> cal_o.gain > 0;
   endproperty
   a_gain_unsigned: assert property (p_gain_unsigned) else $error("gain treated as signed"); // [R07]

   // the datapath sees unity gain straight out of reset
   property p_gain_reset_view;
      @(posedge clk_i) $fell(rst_i) |-> cal_o.gain == {RST_GAIN_HIGH, RST_GAIN_LOW[LOWBYTE_HI:LOWBYTE_LO]};
   endproperty
   a_gain_reset_view: assert property (p_gain_reset_view) else $error("gain reset view wrong"); // [R08]

   // the delay field spans both lanes, so only a full write is checked
   property p_delay_write;
      @(posedge clk_i) disable iff (rst_i) wr_en && hit_cfg && be == 2'h3 |=>
         cal_o.sample_delay == $past(dat_i[PHASE_HI:PHASE_LO]);
   endproperty
   a_delay_write: assert property (p_delay_write) else $error("sample delay write lost"); // [R09]

   // delay is signed: its top bit makes it negative
   property p_delay_sign;
      @(posedge clk_i) disable iff (rst_i) (cal_o.sample_delay < 0) == cfg2[PHASE_HI];
   endproperty
   a_delay_sign: assert property (p_delay_sign) else $error("sample delay sign wrong"); // [R09]

   // highpass override follows a low-lane write
   property p_hp_write;
      @(posedge clk_i) disable iff (rst_i) wr_en && hit_cfg && be[0] |=> cal_o.highpass_off == $past(dat_i[HPOFF_BIT]);
   endproperty
   a_hp_write: assert property (p_hp_write) else $error("highpass override write lost"); // [R10]

   // source select follows a low-lane write
   property p_src_write;
      @(posedge clk_i) disable iff (rst_i) wr_en && hit_cfg && be[0] |=>
         cal_o.input_select == $past(dat_i[SEL_HI:SEL_LO]);
   endproperty
   a_src_write: assert property (p_src_write) else $error("input select write lost"); // [R11]

   // out of reset: no delay, global highpass control, normal pins
   property p_cfg_reset_view;
      @(posedge clk_i) $fell(rst_i) |->
         cal_o.sample_delay == 0 && !cal_o.highpass_off && cal_o.input_select == SRC_PINS;
   endproperty
   a_cfg_reset_view: assert property (p_cfg_reset_view) else $error("config reset view wrong"); // [R12]

   // offset low and the bottom offset byte start at zero
   property p_ofs_low_reset;
      @(posedge clk_i) $fell(rst_i) |-> ofs_low == RST_OFS_LOW && cal_o.offset[7:0] == 8'h00;
   endproperty
   a_ofs_low_reset: assert property (p_ofs_low_reset) else $error("offset low reset wrong"); // [R13]

   // offset high and the top offset bits start at zero
   property p_ofs_high_reset;
      @(posedge clk_i) $fell(rst_i) |-> ofs_high == RST_OFS_HIGH && cal_o.offset[23:8] == RST_OFS_HIGH;
   endproperty
   a_ofs_high_reset: assert property (p_ofs_high_reset) else $error("offset high reset wrong"); // [R14]

   // a read at the offset high index returns that word
   property p_ofs_high_read;
      @(posedge clk_i) disable iff (rst_i) ack_ff && !$past(we_i) && $past(hit_oh) |-> dat_o[15:0] == $past(ofs_high);
   endproperty
   a_ofs_high_read: assert property (p_ofs_high_read) else $error("offset high read wrong"); // [R14]

   // reserved config bits read back as zero
   property p_cfg_rsv_read;
      @(posedge clk_i) disable iff (rst_i) ack_ff && $past(hit_cfg) |-> (dat_o[15:0] & ~MASK_CFG2) == 16'h0000;
   endproperty
   a_cfg_rsv_read: assert property (p_cfg_rsv_read) else $error("config reserved bits read nonzero"); // [R15]

   // without a write the datapath values hold, reads disturb nothing
   property p_quiet_hold;
      @(posedge clk_i) disable iff (rst_i) !wr_en |=> $stable(cal_o);
   endproperty
   a_quiet_hold: assert property (p_quiet_hold) else $error("datapath value moved without a write"); // [R16]

   // bus handshake: one registered answer per taken request

   // an acknowledge always answers a request
   property p_ack_needs_req;
      @(posedge clk_i) disable iff (rst_i) ack_ff |-> $past(req);
   endproperty
   a_ack_needs_req: assert property (p_ack_needs_req) else $error("ack without request");

   // acknowledge lasts a single cycle even if the master keeps strobing
   property p_ack_one_cycle;
      @(posedge clk_i) disable iff (rst_i) ack_ff |=> !ack_ff;
   endproperty
   a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack longer than one cycle");

   // every taken write is answered on the next edge
   property p_write_ack;
      @(posedge clk_i) disable iff (rst_i) wr_en |=> ack_ff;
   endproperty
   a_write_ack: assert property (p_write_ack) else $error("write not acknowledged");

   // registers are sixteen bits, so the upper read half is always zero
   property p_rdata_upper;
      @(posedge clk_i) disable iff (rst_i) ack_ff |-> dat_o[31:16] == 16'h0000;
   endproperty
   a_rdata_upper: assert property (p_rdata_upper) else $error("upper read data nonzero");

   // unmapped indices answer with zero rather than stalling the bus
   property p_unmapped_read;
      @(posedge clk_i) disable iff (rst_i) ack_ff && !$past(we_i) && !$past(any_hit) |-> dat_o == 32'h0000_0000;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero");
endmodule : calreg_bank

// ===== verif/calreg_bank_tb.sv
// self-checking bench for the calibration register slice
`timescale 1ns/1ps
module calreg_bank_tb import calreg_pkg::*; ();
   // bus and clock drive
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack_o;
   cal_out_t cal_o;
   logic [15:0] shadow [5]; // expected register contents, index 0 is offset high
   logic [15:0] q [$]; // expected read data, oldest first
   logic [31:0] seed = 32'hc9a9;
   int n_fail = 0;
   int checks = 0;
   int cycles = 0;
   calreg_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cal_o(cal_o));
   // 200 MHz clock
   initial forever #2.5 clk_i = ~clk_i;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   // one classic cycle; upper data half is noise the slice must ignore
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= {seed[31:16], d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb
   // index -1 and 5 fall outside the map
   task automatic wr(input int i, input logic [15:0] d, input logic [3:0] s);
      logic [15:0] bm;
      // writable bits of the selected lanes; reserved bits stay clear
      bm = {{8{s[1]}}, {8{s[0]}}} & ((i == 1 || i == 3) ? MASK_LOW : (i == 4) ? MASK_CFG2 : MASK_FULL);
      if (i >= 0 && i < 5) begin
         shadow[i] = (shadow[i] & ~bm) | (d & bm);
      end
      wb(1'b1, 8'(8'h3c + 4 * i), d, s);
   endtask : wr
   task automatic rd(input int i);
      q.push_back((i >= 0 && i < 5) ? shadow[i] : 16'h0000);
      wb(1'b0, 8'(8'h3c + 4 * i), 16'h0000, 4'hf);
   endtask : rd
   // datapath view must follow the registers at once
   task automatic cal_check();
      check(64'(cal_o.offset), {{40{shadow[0][15]}}, shadow[0], shadow[1][15:8]});
      check(64'(cal_o.gain), {40'h0, shadow[2], shadow[3][15:8]});
      check(64'(cal_o.sample_delay), {{54{shadow[4][15]}}, shadow[4][15:6]});
      check({cal_o.highpass_off, cal_o.input_select}, shadow[4][2:0]);
   endtask : cal_check
   task automatic do_reset();
      rst_i <= 1'b1;
      shadow = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset
   // read watcher and hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (ack_o === 1'b1 && we_i === 1'b0) begin
         check(dat_o, q.size() > 0 ? {16'h0, q.pop_front()} : 32'hx);
      end
      if (cycles == 3000) begin
         n_fail++;
         results();
      end
   end
   initial begin
      do_reset();
      cal_check();
      for (int i = -1; i < 6; i++) rd(i);
      // all ones everywhere, reserved bits must stay clear
      for (int i = -1; i < 6; i++) wr(i, 16'hffff, 4'hf);
      for (int i = -1; i < 6; i++) rd(i);
      cal_check();
      // every source code with highpass on and off, noise in reserved bits
      for (int k = 0; k < 8; k++) begin
         void'(rnd());
         wr(4, {seed[15:3], 3'(k)}, 4'h3);
         rd(4);
         cal_check();
      end
      // random data and byte selects, each write followed by a read
      for (int n = 0; n < 40; n++) begin
         void'(rnd());
         wr(n % 7 - 1, seed[15:0], seed[19:16]);
         rd(n % 7 - 1);
         cal_check();
      end
      // second reset in mid-run restores defaults
      do_reset();
      cal_check();
      for (int i = -1; i < 6; i++) rd(i);
      results();
   end
endmodule : calreg_bank_tb
